// ===== core/sprt_map.vh
// constants for the precharge and refresh timing block
// Notes on behaviour
// - write with auto close starts closing write recovery cycles after burst end.
// - close period counts from latest precharge to that bank, ends after row close time.
// - seamless other-bank bursts after auto close; auto close bursts never cut short.
// - refresh is cs low, line0 low, line1 low, line2 high; line3 picks kind.
// - single bank refresh only on eight-bank devices.
// - single bank refresh targets counter bank, round robin 0..7 then wraps.
// - bank counter cleared by reset command and on self refresh exit.
// - read auto close starts closing at max(BL/2, BL/2-2+RU(rtp)).
// - without auto close the bank stays open after the burst.
// - all bank refresh also clears the bank counter.
`ifndef SPRT_MAP_VH
`define SPRT_MAP_VH
`define SPRT_CLK_NS 40
`define SPRT_BURST_LEN 8
`define SPRT_WRITE_LAT 4
`define SPRT_RTP_NS 8
`define SPRT_WR_NS 15
`define SPRT_RP_NS 18
`define SPRT_RTP_CYC ((`SPRT_RTP_NS + `SPRT_CLK_NS - 1) / `SPRT_CLK_NS)
`define SPRT_WR_CYC ((`SPRT_WR_NS + `SPRT_CLK_NS - 1) / `SPRT_CLK_NS)
`define SPRT_RP_CYC ((`SPRT_RP_NS + `SPRT_CLK_NS - 1) / `SPRT_CLK_NS)
`define SPRT_BANKS 8
`define SPRT_CNT_W 6
`endif

// ===== core/sprt_bank.v
// one bank: open state and delayed auto close timer
`timescale 1ns/1ps
`default_nettype none
`include "sprt_map.vh"
module sprt_bank (
    // clock and reset
    input wire clk_sys,
    input wire rst_b,
    // events for this bank
    input wire activate,
    input wire close_now,
    input wire arm_close,
    input wire [5:0] arm_delay,
    // state
    output reg bank_open,
    output reg closing,
    output reg auto_start
);
    reg [5:0] delay_cnt;
    reg armed;
    reg [5:0] rp_cnt;
    // close period in system clocks; counter is only six bits wide
    localparam [31:0] RP_FULL = `SPRT_RP_CYC;
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bank_open <= 1'b0;
            armed <= 1'b0;
            delay_cnt <= 6'h00;
            auto_start <= 1'b0;
            closing <= 1'b0;
            rp_cnt <= 6'h00;
        end else begin
            auto_start <= 1'b0;
            if (activate) begin
                bank_open <= 1'b1;
                closing <= 1'b0;
            end
            if (arm_close) begin
                // burst keeps running; close is only scheduled
                armed <= 1'b1;
                delay_cnt <= arm_delay;
            end else if (armed) begin
                if (delay_cnt <= 6'h01) begin
                    armed <= 1'b0;
                    auto_start <= 1'b1;
                    bank_open <= 1'b0;
                    closing <= 1'b1;
                    rp_cnt <= RP_FULL[5:0];
                end else begin
                    delay_cnt <= delay_cnt - 6'h01;
                end
            end
            if (close_now) begin
                // latest precharge restarts the close period
                bank_open <= 1'b0;
                armed <= 1'b0;
                closing <= 1'b1;
                rp_cnt <= RP_FULL[5:0];
            end else if (closing && !(armed && delay_cnt <= 6'h01) && !activate) begin
                if (rp_cnt <= 6'h01)
                    closing <= 1'b0;
                else
                    rp_cnt <= rp_cnt - 6'h01;
            end
        end
    end
endmodule // sprt_bank
`default_nettype wire

// ===== core/sprt_core.v
// command decode, bank state and refresh bank counter
`timescale 1ns/1ps
`default_nettype none
`include "sprt_map.vh"
module sprt_core (
    // clock and reset
    input wire clk_sys,
    input wire rst_b,
    // memory clock and command bus from controller pins
    input wire mem_clk,
    input wire cs_b,
    input wire [3:0] cmd_line,
    input wire cmd_line0_falling,
    input wire all_bank_flag,
    input wire [2:0] bank_addr,
    // other command events decoded elsewhere
    input wire reset_cmd,
    input wire self_refresh_exit,
    // device organisation strap, high for eight banks
    input wire eight_banks,
    // status
    output reg [2:0] refresh_bank,
    output reg refresh_pulse,
    output reg refresh_all_pulse,
    output reg refresh_rejected,
    output reg [7:0] bank_open,
    output reg [7:0] bank_closing,
    output reg [7:0] auto_close_start
);
    // every pin passes two flops before any logic reads it
    reg mclk_s1;
    reg mclk_s2;
    reg mclk_d;
    reg cs_s1;
    reg cs_s2;
    reg [3:0] cmd_s1;
    reg [3:0] cmd_s2;
    reg auto_s1;
    reg auto_s2;
    reg ab_s1;
    reg ab_s2;
    reg [2:0] ba_s1;
    reg [2:0] ba_s2;
    reg eight_s1;
    reg eight_s2;
    reg [1:0] rst_cmd_s;
    reg [1:0] srx_s;
    reg srx_d;
    // memory clock; the delayed copy reads only the second flop
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mclk_s1 <= 1'b0;
            mclk_s2 <= 1'b0;
            mclk_d <= 1'b0;
        end else begin
            mclk_s1 <= mem_clk;
            mclk_s2 <= mclk_s1;
            mclk_d <= mclk_s2;
        end
    end
    // select idles high so leaving reset never looks like a command
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
        end else begin
            cs_s1 <= cs_b;
            cs_s2 <= cs_s1;
        end
    end
    // command and address lines; must stay put across a memory clock rise
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cmd_s1 <= 4'h0;
            cmd_s2 <= 4'h0;
            auto_s1 <= 1'b0;
            auto_s2 <= 1'b0;
            ab_s1 <= 1'b0;
            ab_s2 <= 1'b0;
            ba_s1 <= 3'h0;
            ba_s2 <= 3'h0;
        end else begin
            cmd_s1 <= cmd_line;
            cmd_s2 <= cmd_s1;
            auto_s1 <= cmd_line0_falling;
            auto_s2 <= auto_s1;
            ab_s1 <= all_bank_flag;
            ab_s2 <= ab_s1;
            ba_s1 <= bank_addr;
            ba_s2 <= ba_s1;
        end
    end
    // organisation strap
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            eight_s1 <= 1'b0;
            eight_s2 <= 1'b0;
        end else begin
            eight_s1 <= eight_banks;
            eight_s2 <= eight_s1;
        end
    end
    // counter sync events; self refresh exit acts on its rising edge only
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_cmd_s <= 2'b00;
            srx_s <= 2'b00;
            srx_d <= 1'b0;
        end else begin
            rst_cmd_s <= {rst_cmd_s[0], reset_cmd};
            srx_s <= {srx_s[0], self_refresh_exit};
            srx_d <= srx_s[1];
        end
    end
    wire m_rise = mclk_s2 && !mclk_d;
    wire cmd_ok = m_rise && !cs_s2;
    // command decode on memory clock rising edge
    reg dec_act;
    reg dec_wr;
    reg dec_rd;
    reg dec_pre;
    reg dec_single_bank_refresh;
    reg dec_all_bank_refresh;
    always @* begin
        dec_act = 1'b0;
        dec_wr = 1'b0;
        dec_rd = 1'b0;
        dec_pre = 1'b0;
        dec_single_bank_refresh = 1'b0;
        dec_all_bank_refresh = 1'b0;
        if (cmd_ok) begin
            case (cmd_s2)
                4'h2, 4'h6, 4'ha, 4'he: begin
                    dec_act = 1'b1;
                end
                4'h0, 4'h8: begin
                    dec_wr = 1'b1;
                end
                4'h5, 4'hd: begin
                    dec_rd = 1'b1;
                end
                4'hb: begin
                    dec_pre = 1'b1;
                end
                4'h4: begin
                    dec_single_bank_refresh = 1'b1;
                end
                4'hc: begin
                    dec_all_bank_refresh = 1'b1;
                end
                default: begin
                    // other commands leave precharge and refresh state alone
                    dec_act = 1'b0;
                end
            endcase
        end
    end
    // delays counted in system clocks after decode, not memory clocks
    localparam integer RD_LATE_I = `SPRT_BURST_LEN / 2 - 2 + `SPRT_RTP_CYC;
    localparam integer RD_EARLY_I = `SPRT_BURST_LEN / 2;
    localparam [31:0] RD_DLY_W = (RD_LATE_I > RD_EARLY_I) ? RD_LATE_I : RD_EARLY_I;
    localparam [31:0] WR_DLY_W = `SPRT_WRITE_LAT + `SPRT_BURST_LEN / 2 + `SPRT_WR_CYC;
    wire [5:0] rd_dly = RD_DLY_W[5:0];
    wire [5:0] wr_dly = WR_DLY_W[5:0];
    wire [5:0] arm_dly = dec_rd ? rd_dly : wr_dly;
    wire [7:0] sel = 8'h01 << ba_s2;
    wire [7:0] b_open;
    wire [7:0] b_closing;
    wire [7:0] b_start;
    // precharge all hits every bank whatever the bank address
    wire [7:0] pre_hit = dec_pre ? (ab_s2 ? 8'hff : sel) : 8'h00;
    wire [7:0] act_hit = dec_act ? sel : 8'h00;
    // auto close only when the flag rides on the read or write
    wire [7:0] arm_hit = ((dec_rd || dec_wr) && auto_s2) ? sel : 8'h00;
    genvar g;
    generate
        for (g = 0; g < `SPRT_BANKS; g = g + 1) begin : g_bank
            // without auto close only activate and precharge touch state
            sprt_bank u_bank (
                .clk_sys(clk_sys),
                .rst_b(rst_b),
                .activate(act_hit[g]),
                .close_now(pre_hit[g]),
                .arm_close(arm_hit[g]),
                .arm_delay(arm_dly),
                .bank_open(b_open[g]),
                .closing(b_closing[g]),
                .auto_start(b_start[g])
            );
        end
    endgenerate
    // refresh bank counter
    reg [2:0] next_refresh_bank;
    wire exit_edge = srx_s[1] && !srx_d;
    wire sync_clear = rst_cmd_s[1] || exit_edge || dec_all_bank_refresh;
    // a four-bank part refuses the per-bank form; counter holds
    wire pb_take = dec_single_bank_refresh && eight_s2;
    always @* begin
        next_refresh_bank = refresh_bank;
        if (sync_clear) begin
            next_refresh_bank = 3'h0;
        end else if (pb_take) begin
            next_refresh_bank = refresh_bank + 3'h1;
        end
    end
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            refresh_bank <= 3'h0;
        end else begin
            refresh_bank <= next_refresh_bank;
        end
    end
    // one-cycle refresh pulses
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            refresh_pulse <= 1'b0;
            refresh_all_pulse <= 1'b0;
            refresh_rejected <= 1'b0;
        end else begin
            refresh_pulse <= pb_take;
            refresh_all_pulse <= dec_all_bank_refresh;
            refresh_rejected <= dec_single_bank_refresh && !eight_s2;
        end
    end
    // bank status mirrors, one clock behind the bank flops
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bank_open <= 8'h00;
            bank_closing <= 8'h00;
            auto_close_start <= 8'h00;
        end else begin
            bank_open <= b_open;
            bank_closing <= b_closing;
            auto_close_start <= b_start;
        end
    end
endmodule // sprt_core
`default_nettype wire

// ===== sim/sprt_core_asserts.sv
// checker for refresh counter and bank close outputs
`timescale 1ns/1ps
`default_nettype none
module sprt_core_asserts (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // counter sync
    input wire logic reset_cmd,
    input wire logic self_refresh_exit,
    // status
    input wire logic [2:0] refresh_bank,
    input wire logic refresh_pulse,
    input wire logic refresh_all_pulse,
    input wire logic refresh_rejected,
    input wire logic [7:0] bank_open,
    input wire logic [7:0] auto_close_start
);
    logic [7:0] last_st;
    always @(posedge clk_sys or negedge rst_b) begin
        last_st <= !rst_b ? 8'h00 : (|auto_close_start ? auto_close_start : last_st);
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence s_zero; ##[1:5] refresh_bank == 3'h0; endsequence
    property p_excl; !(refresh_pulse && (refresh_all_pulse || refresh_rejected)); endproperty
    a_excl: assert property (p_excl) else $error("refresh pulses overlap");
    property p_once; refresh_pulse |=> !refresh_pulse; endproperty
    a_once: assert property (p_once) else $error("refresh pulse too long");
    property p_step; refresh_pulse |-> ##1 refresh_bank == $past(refresh_bank, 2) + 3'h1; endproperty
    a_step: assert property (p_step) else $error("bank counter step wrong");
    property p_all; refresh_all_pulse |-> ##1 refresh_bank == 3'h0; endproperty
    a_all: assert property (p_all) else $error("all refresh left counter");
    property p_rej; refresh_rejected |-> ##1 refresh_bank == $past(refresh_bank, 2); endproperty
    a_rej: assert property (p_rej) else $error("rejected refresh moved counter");
    property p_rcmd; $rose(reset_cmd) |-> s_zero; endproperty
    a_rcmd: assert property (p_rcmd) else $error("reset command kept counter");
    property p_srx; $rose(self_refresh_exit) |-> s_zero; endproperty
    a_srx: assert property (p_srx) else $error("self refresh exit kept counter");
    property p_ac; |auto_close_start |-> ##[1:4] (bank_open & last_st) == 8'h00; endproperty
    a_ac: assert property (p_ac) else $error("bank open after auto close");
endmodule // sprt_core_asserts
`default_nettype wire

// ===== sim/sprt_ctrl_model.sv
// controller model: one memory clock pulse per command
`timescale 1ns/1ps
`default_nettype none
module sprt_ctrl_model (
    // clock
    input wire logic clk_sys,
    // command pins
    output logic mem_clk,
    output logic cs_b,
    output wire logic [3:0] cmd_line,
    output wire logic cmd_line0_falling,
    output wire logic all_bank_flag,
    output wire logic [2:0] bank_addr
);
    logic [8:0] pins = 9'h0a5;
    initial mem_clk = 1'b0;
    initial cs_b = 1'b1;
    assign {cmd_line, cmd_line0_falling, all_bank_flag, bank_addr} = pins;
    task automatic send(input logic [8:0] c);
        @(posedge clk_sys);
        cs_b <= 1'b0;
        pins <= c;
        repeat (4) @(posedge clk_sys);
        mem_clk <= 1'b1;
        repeat (4) @(posedge clk_sys);
        mem_clk <= 1'b0;
        repeat (4) @(posedge clk_sys);
        // released pins invert so stale values never match
        cs_b <= 1'b1;
        pins <= ~c;
        // wide gap meets every close and refresh spacing
        repeat (16) @(posedge clk_sys);
    endtask
endmodule // sprt_ctrl_model
`default_nettype wire

// ===== sim/test_sdram_precharge_refresh_timing.sv
// testbench for the precharge and refresh timing block
`timescale 1ns/1ps
`default_nettype none
module test_sdram_precharge_refresh_timing;
    logic clk_sys = 1'b0, rst_b = 1'b0, reset_cmd = 1'b0;
    logic self_refresh_exit = 1'b0, eight_banks = 1'b1;
    wire logic mem_clk, cs_b, cmd_line0_falling, all_bank_flag;
    wire logic [3:0] cmd_line;
    wire logic [2:0] bank_addr;
    logic [2:0] refresh_bank;
    logic refresh_pulse, refresh_all_pulse, refresh_rejected;
    logic [7:0] bank_open, bank_closing, auto_close_start;
    int miscompares = 0, n_compared = 0, cycles = 0, n_ref = 0, n_rej = 0;
    always #20 clk_sys = ~clk_sys;
    sprt_ctrl_model ctrl (.clk_sys(clk_sys), .mem_clk(mem_clk), .cs_b(cs_b),
        .cmd_line(cmd_line), .cmd_line0_falling(cmd_line0_falling),
        .all_bank_flag(all_bank_flag), .bank_addr(bank_addr));
    sprt_core dut (.clk_sys(clk_sys), .rst_b(rst_b), .mem_clk(mem_clk), .cs_b(cs_b),
        .cmd_line(cmd_line), .cmd_line0_falling(cmd_line0_falling),
        .all_bank_flag(all_bank_flag), .bank_addr(bank_addr), .reset_cmd(reset_cmd),
        .self_refresh_exit(self_refresh_exit), .eight_banks(eight_banks),
        .refresh_bank(refresh_bank), .refresh_pulse(refresh_pulse),
        .refresh_all_pulse(refresh_all_pulse), .refresh_rejected(refresh_rejected),
        .bank_open(bank_open), .bank_closing(bank_closing),
        .auto_close_start(auto_close_start));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        if (miscompares == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        n_ref += refresh_pulse;
        n_rej += refresh_rejected;
        if (cycles == 3000) begin
            miscompares++;
            summarize();
        end
    end
    task automatic t_refresh();
        for (int i = 1; i < 10; i++) begin
            ctrl.send(9'h080);
            check({5'h0, refresh_bank}, 8'(i % 8));
        end
        check(8'(n_ref), 8'h09);
        ctrl.send(9'h180);
        check({5'h0, refresh_bank}, 8'h00);
        for (int k = 0; k < 2; k++) begin
            ctrl.send(9'h080);
            reset_cmd <= (k == 0);
            self_refresh_exit <= (k == 1);
            repeat (6) @(posedge clk_sys);
            {reset_cmd, self_refresh_exit} <= 2'b00;
            repeat (4) @(posedge clk_sys);
            check({5'h0, refresh_bank}, 8'h00);
        end
        eight_banks <= 1'b0;
        ctrl.send(9'h080);
        check(8'(n_rej), 8'h01);
        check({5'h0, refresh_bank}, 8'h00);
        eight_banks <= 1'b1;
    endtask
    task automatic t_banks();
        ctrl.send(9'h042);
        ctrl.send(9'h0b2);
        check(bank_open, 8'h00);
        ctrl.send(9'h045);
        ctrl.send(9'h005);
        check(bank_open, 8'h20);
        ctrl.send(9'h015);
        check(bank_open, 8'h00);
        ctrl.send(9'h041);
        ctrl.send(9'h16b);
        check(bank_open, 8'h00);
        check(bank_closing, 8'h00);
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        check(bank_open, 8'h00);
        repeat (4) @(posedge clk_sys);
        t_refresh();
        t_banks();
        summarize();
    end
endmodule // test_sdram_precharge_refresh_timing
bind sprt_core sprt_core_asserts chk (.clk_sys(clk_sys), .rst_b(rst_b),
    .reset_cmd(reset_cmd), .self_refresh_exit(self_refresh_exit),
    .refresh_bank(refresh_bank), .refresh_pulse(refresh_pulse),
    .refresh_all_pulse(refresh_all_pulse), .refresh_rejected(refresh_rejected),
    .bank_open(bank_open), .auto_close_start(auto_close_start));
`default_nettype wire
